//--- design/privileged_instr_decoder.sv
/*
 Decoder and executor for the supervisor-only instruction group: user stack pointer
 moves, control register moves, alternate space moves, OR into status and the
 coprocessor conditional branch. Assumes the core presents one instruction with its
 extension words and current register values per request, reads register outputs
 combinationally and performs the memory access; the coprocessor answers the
 condition in the same cycle. APB gives variant selection and a status readout.
*/
// What this block does
// - User stack pointer move copies long between it and An, else trap.
// - Direction 0 loads user stack pointer from An, 1 loads An.
// - Control move transfers 32 bits, unimplemented bits zero, flags kept.
// - Control move opcode bit 0: 0 control to general, 1 general to control.
// - Extension bit 15 data/address, bits 14-12 register, 11-0 control code.
// - Codes 000, 001, 800, 801 select space codes, user sp, vector base.
// - Non-base variants add 002 cache ctrl, 803, 804; cached variant also adds 802.
// - Managed variant 003-007, 805-807; embedded variant 004-007 access ctrl.
// - Unassigned control code raises illegal instruction.
// - Alternate move writes via destination space, reads via source space.
// - Data register load keeps upper bits; address register sign-extends.
// - Size 00 byte, 01 word, 10 long.
// - Extension: type bit 15, register 14-12, direction 11, rest zero.
// - Only memory alterable addressing modes accepted.
// - Same register source and auto-updated target stores updated value.
// - Merged control bit 2, in any variant, converts program spaces 6/2 to data spaces 5/1.
// - OR immediate into whole status register in supervisor state.
// - Extend, negative, zero, overflow, carry set by immediate bits 4-0.
// - Branch adds signed displacement to address of displacement word.
// - Branch word carries size bit and 6-bit condition for the coprocessor.
// - Size bit 0 selects 16-bit, 1 selects 32-bit displacement.
`timescale 1ns/1ns
module privileged_instr_decoder
   import priv_pkg::*;
#(
   parameter logic [1:0] DEFAULT_VARIANT = VAR_MMU
) (
   input wire logic mclk,
   input wire logic rst,
   input wire instr_t instr,
   input wire logic supervisor,
   input wire logic [31:0] an_val,
   input wire logic [31:0] rn_val,
   input wire logic [31:0] cr_val,
   input wire logic [31:0] mem_rdata,
   input wire logic [15:0] sr_val,
   input wire logic [31:0] user_sp_val,
   input wire logic cc_true,
   output logic [5:0] cc_query,
   output result_t result,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [15:0] count_reg;
   exc_t last_exc_reg;
   result_t res_next;
   wire logic [1:0] variant = ctrl_reg[1:0];
   wire logic merged = ctrl_reg[2];
   wire logic [15:0] op = instr.op;
   wire logic [15:0] ext = instr.ext;

   // Opcode classes
   wire logic is_usp = (op & USP_MOVE_MSK) == USP_MOVE_PAT;
   wire logic is_crm = (op & CRM_MSK) == CRM_PAT;
   wire logic is_asm = (op & ASM_MSK) == ASM_PAT && op[7:6] != 2'h3;
   wire logic is_ors = op == ORS_PAT;
   wire logic is_cpb = (op & CPB_MSK) == CPB_PAT;
   wire logic is_priv = is_usp | is_crm | is_asm | is_ors | is_cpb;

   // Control register code legality per variant
   wire logic [11:0] crc = ext[11:0];
   wire logic cr_base = crc == CR_SRC_SPACE || crc == CR_DST_SPACE
      || crc == CR_USER_SP || crc == CR_VEC_BASE;
   wire logic cached = variant != VAR_BASE;
   wire logic cr_cache = cached && (crc == CR_CACHE_CTRL || crc == CR_MASTER_SP
      || crc == CR_INTR_SP || (crc == CR_CACHE_ADDR && variant == VAR_CACHED));
   wire logic cr_tt = crc >= CR_TT_FIRST && crc <= CR_TT_LAST;
   wire logic cr_mmu = (variant == VAR_MMU && (crc == CR_XLAT_CTRL || cr_tt
      || (crc >= CR_XLAT_STAT && crc <= CR_SUP_ROOT)))
      || (variant == VAR_EMBED && cr_tt);
   wire logic cr_legal = cr_base | cr_cache | cr_mmu;

   // Alternate space checks
   wire logic [2:0] ea_mode = op[5:3];
   wire logic [2:0] ea_reg = op[2:0];
   wire logic ea_ok = (ea_mode >= 3'h2 && ea_mode <= 3'h6)
      || (ea_mode == 3'h7 && ea_reg <= 3'h1);
   wire logic ext_ok = ext[10:0] == 11'h000;
   wire logic size_ok = op[7:6] != 2'h3;
   wire logic asm_wr = ext[EXT_ASM_DIR_BIT];
   // Source space field is only two bits wide, so reads reach codes 0 to 3 only
   wire logic [2:0] raw_space = asm_wr ? ctrl_reg[7:5] : {1'b0, ctrl_reg[4:3]};
   logic [2:0] space_conv;
   always_comb begin
      space_conv = raw_space;
      if (merged && raw_space == SPACE_SPROG) begin
         space_conv = SPACE_SDATA;
      end else if (merged && raw_space == SPACE_UPROG) begin
         space_conv = SPACE_UDATA;
      end
   end

   // Loaded operand forming
   logic [31:0] asm_load;
   logic [3:0] asm_bmask;
   always_comb begin
      asm_load = mem_rdata;
      asm_bmask = 4'hF;
      case (op[7:6])
         SZ_BYTE: begin
            asm_load = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
            asm_bmask = 4'h1;
         end
         SZ_WORD: begin
            asm_load = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
            asm_bmask = 4'h3;
         end
         default: begin
            asm_load = mem_rdata;
            asm_bmask = 4'hF;
         end
      endcase
      if (ext[EXT_AD_BIT]) begin
         asm_bmask = 4'hF;
      end
   end

   wire logic [31:0] cpb_disp = op[CPB_SIZE_BIT] ? instr.disp
      : {{16{instr.disp[15]}}, instr.disp[15:0]};
   // The displacement word follows the opcode word
   wire logic [31:0] disp_pc = instr.pc + 32'h0000_0002;

   always_comb begin
      res_next = '0;
      res_next.valid = instr.valid;
      res_next.cc_code = op[5:0];
      if (!instr.valid || !is_priv) begin
         res_next.kind = OP_NONE;
      end else if (!supervisor) begin
         res_next.exc = EXC_PRIV;
      end else if (is_usp) begin
         res_next.kind = OP_USP;
         res_next.gr_addr = 1'b1;
         res_next.gr_num = op[2:0];
         res_next.gr_bmask = 4'hF;
         res_next.cr_code = CR_USER_SP;
         if (op[DIR_BIT]) begin
            res_next.gr_we = 1'b1;
            res_next.gr_data = user_sp_val;
         end else begin
            res_next.cr_we = 1'b1;
            res_next.cr_data = an_val;
         end
      end else if (is_crm) begin
         res_next.kind = OP_CRM;
         res_next.gr_addr = ext[EXT_AD_BIT];
         res_next.gr_num = ext[14:12];
         res_next.cr_code = crc;
         res_next.gr_bmask = 4'hF;
         if (!cr_legal) begin
            res_next.exc = EXC_ILLEGAL;
         end else if (op[0]) begin
            res_next.cr_we = 1'b1;
            res_next.cr_data = rn_val;
         end else begin
            res_next.gr_we = 1'b1;
            res_next.gr_data = cr_val;
         end
      end else if (is_asm) begin
         res_next.kind = OP_ASM;
         res_next.gr_addr = ext[EXT_AD_BIT];
         res_next.gr_num = ext[14:12];
         res_next.mem_size = op[7:6];
         res_next.mem_space = space_conv;
         if (!ea_ok || !ext_ok || !size_ok) begin
            res_next.exc = EXC_ILLEGAL;
         end else begin
            res_next.mem_req = 1'b1;
            res_next.mem_write = asm_wr;
            // rn_val is the register after any address update
            res_next.cr_data = rn_val;
            res_next.gr_we = !asm_wr;
            res_next.gr_data = asm_load;
            res_next.gr_bmask = asm_bmask;
         end
      end else if (is_ors) begin
         res_next.kind = OP_ORS;
         res_next.sr_we = 1'b1;
         res_next.sr_data = sr_val | ext;
      end else begin
         res_next.kind = OP_CPB;
         res_next.pc_we = cc_true;
         res_next.pc_data = disp_pc + cpb_disp;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result <= '0;
         cc_query <= 6'h00;
      end else begin
         result <= res_next;
         cc_query <= op[5:0];
      end
   end

   // APB slave: control, status, count of supervisor-state privileged ops
   wire logic apb_acc = psel && penable;
   wire logic apb_wr = apb_acc && pwrite;
   wire logic hit_ctrl = paddr == ADDR_CTRL;
   wire logic hit_stat = paddr == ADDR_STATUS;
   wire logic hit_cnt = paddr == ADDR_COUNT;
   wire logic hit_any = hit_ctrl | hit_stat | hit_cnt;
   wire logic [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_reg}
      : hit_stat ? {30'h00000000, last_exc_reg}
      : hit_cnt ? {16'h0000, count_reg} : 32'h0000_0000;
   assign ctrl_next = (apb_wr && hit_ctrl) ? pwdata[7:0] : ctrl_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET | {6'h00, DEFAULT_VARIANT};
         count_reg <= 16'h0000;
         last_exc_reg <= EXC_NONE;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         if (res_next.valid && res_next.kind != OP_NONE) begin
            count_reg <= count_reg + 16'h0001;
         end
         if (res_next.valid && is_priv) begin
            last_exc_reg <= res_next.exc;
         end
         pready <= psel && !pready;
         pslverr <= psel && !pready && !hit_any;
         prdata <= rd_mux;
      end
   end

   a_user_trap: assert property (@(posedge mclk) disable iff (rst)
      instr.valid && is_priv && !supervisor |=> result.exc == EXC_PRIV && !result.gr_we
      && !result.cr_we && !result.sr_we && !result.mem_req && !result.pc_we)
      else $error("user state privileged op changed state");
   a_usp_dir: assert property (@(posedge mclk) disable iff (rst)
      instr.valid && supervisor && is_usp |=> result.gr_we == $past(op[DIR_BIT])
      && result.cr_we != $past(op[DIR_BIT]))
      else $error("user sp move direction wrong");
   a_crm_illegal: assert property (@(posedge mclk) disable iff (rst)
      instr.valid && supervisor && is_crm && !cr_legal |=> result.exc == EXC_ILLEGAL)
      else $error("bad control code accepted");
   a_crm_dir: assert property (@(posedge mclk) disable iff (rst)
      instr.valid && supervisor && is_crm && cr_legal |=> result.cr_we == $past(op[0]))
      else $error("control move direction wrong");
   a_ea_reject: assert property (@(posedge mclk) disable iff (rst)
      instr.valid && supervisor && is_asm && ea_mode <= 3'h1 |=> !result.mem_req)
      else $error("register direct mode accepted");
   a_space_merge: assert property (@(posedge mclk) disable iff (rst)
      instr.valid && supervisor && is_asm && merged |=> result.mem_space != SPACE_SPROG
      && result.mem_space != SPACE_UPROG)
      else $error("program space not converted");
   a_ors_flags: assert property (@(posedge mclk) disable iff (rst)
      instr.valid && supervisor && is_ors |=> result.sr_data[4:0]
      == ($past(sr_val[4:0]) | $past(ext[4:0])))
      else $error("status or wrong");
   a_branch_tgt: assert property (@(posedge mclk) disable iff (rst)
      instr.valid && supervisor && is_cpb && !op[CPB_SIZE_BIT] |=> result.pc_data
      == $past(instr.pc) + 32'h0000_0002 + {{16{$past(instr.disp[15])}}, $past(instr.disp[15:0])})
      else $error("branch target wrong");
endmodule

//--- design/priv_pkg.sv
/*
 Package for the privileged instruction decoder: opcode patterns, field positions,
 control register codes, exception kinds and the APB register map.
 Assumes 16-bit instruction words and 32-bit general registers.
*/
package priv_pkg;
   localparam logic [15:0] USP_MOVE_PAT = 16'h4E60;
   localparam logic [15:0] USP_MOVE_MSK = 16'hFFF0;
   localparam logic [15:0] CRM_PAT = 16'h4E7A;
   localparam logic [15:0] CRM_MSK = 16'hFFFE;
   localparam logic [15:0] ASM_PAT = 16'h0E00;
   localparam logic [15:0] ASM_MSK = 16'hFF00;
   localparam logic [15:0] ORS_PAT = 16'h007C;
   localparam logic [15:0] CPB_PAT = 16'hF080;
   localparam logic [15:0] CPB_MSK = 16'hFF80;
   localparam int DIR_BIT = 3;
   localparam int EXT_AD_BIT = 15;
   localparam int EXT_ASM_DIR_BIT = 11;
   localparam int CPB_SIZE_BIT = 6;
   localparam logic [11:0] CR_SRC_SPACE = 12'h000;
   localparam logic [11:0] CR_DST_SPACE = 12'h001;
   localparam logic [11:0] CR_CACHE_CTRL = 12'h002;
   localparam logic [11:0] CR_XLAT_CTRL = 12'h003;
   localparam logic [11:0] CR_TT_FIRST = 12'h004;
   localparam logic [11:0] CR_TT_LAST = 12'h007;
   localparam logic [11:0] CR_USER_SP = 12'h800;
   localparam logic [11:0] CR_VEC_BASE = 12'h801;
   localparam logic [11:0] CR_CACHE_ADDR = 12'h802;
   localparam logic [11:0] CR_MASTER_SP = 12'h803;
   localparam logic [11:0] CR_INTR_SP = 12'h804;
   localparam logic [11:0] CR_XLAT_STAT = 12'h805;
   localparam logic [11:0] CR_USER_ROOT = 12'h806;
   localparam logic [11:0] CR_SUP_ROOT = 12'h807;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;
   localparam logic [2:0] SPACE_UDATA = 3'h1;
   localparam logic [2:0] SPACE_UPROG = 3'h2;
   localparam logic [2:0] SPACE_SDATA = 3'h5;
   localparam logic [2:0] SPACE_SPROG = 3'h6;
   localparam logic [1:0] VAR_BASE = 2'h0;
   localparam logic [1:0] VAR_CACHED = 2'h1;
   localparam logic [1:0] VAR_MMU = 2'h2;
   localparam logic [1:0] VAR_EMBED = 2'h3;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_COUNT = 12'h008;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   typedef enum logic [1:0] {
      EXC_NONE = 2'b00,
      EXC_PRIV = 2'b01,
      EXC_ILLEGAL = 2'b10
   } exc_t;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_USP = 3'b001,
      OP_CRM = 3'b010,
      OP_ASM = 3'b011,
      OP_ORS = 3'b100,
      OP_CPB = 3'b101
   } op_t;

   typedef struct packed {
      logic valid;
      logic [15:0] op;
      logic [15:0] ext;
      logic [31:0] disp;
      logic [31:0] pc;
   } instr_t;

   typedef struct packed {
      logic valid;
      op_t kind;
      exc_t exc;
      logic gr_we;
      logic gr_addr;
      logic [2:0] gr_num;
      logic [31:0] gr_data;
      logic [3:0] gr_bmask;
      logic cr_we;
      logic [11:0] cr_code;
      logic [31:0] cr_data;
      logic mem_req;
      logic mem_write;
      logic [1:0] mem_size;
      logic [2:0] mem_space;
      logic sr_we;
      logic [15:0] sr_data;
      logic pc_we;
      logic [31:0] pc_data;
      logic [5:0] cc_code;
   } result_t;
endpackage

//--- verif/core_side_model.sv
/*
 Core side of the decoder: register file values and the coprocessor condition answer.
 Assumes the decoder reads these combinationally in the cycle of the request.
*/
`timescale 1ns/1ns
module core_side_model
   import priv_pkg::*;
(
   input wire instr_t instr,
   output logic [31:0] an_val,
   output logic [31:0] rn_val,
   output logic [31:0] cr_val,
   output logic [31:0] mem_rdata,
   output logic [15:0] sr_val,
   output logic [31:0] user_sp_val,
   output logic cc_true
);
   localparam logic [7:0] MMU_FLAGS = 8'hA5;
   wire logic [2:0] flag_idx = instr.op[3:1];
   // Values carry the register number so a wrong selection shows up
   assign an_val = 32'hA0000000 | {29'h0, instr.op[2:0]};
   assign rn_val = {28'hD00D000, instr.ext[15:12]};
   assign cr_val = 32'hC0000000 | {20'h0, instr.ext[11:0]};
   // Sign bits set in byte and word so a missing extension is seen
   assign mem_rdata = 32'h12348081;
   assign sr_val = 16'h2708;
   assign user_sp_val = 32'h00005FF0;
   // Even codes test a flag set, odd ones clear; codes above 001111 answer false
   assign cc_true = (instr.op[5:4] == 2'h0) && (MMU_FLAGS[flag_idx] ^ instr.op[0]);
endmodule

//--- verif/privileged_instr_decoder_test.sv
/*
 Self-checking bench for the privileged instruction decoder: APB tests, a table of instructions,
 then size mask, control space and variant tests. Assumes the core model answers at once.
*/
`timescale 1ns/1ns
module privileged_instr_decoder_test;
   import priv_pkg::*;
   typedef struct packed {
      logic sup; logic [15:0] op; logic [15:0] ext; logic [31:0] disp;
      logic [1:0] exc; logic [4:0] we; logic [31:0] v;
   } row_t;
   // Expected: exception, writes {gr, cr, mem, sr, pc}, main data value
   localparam row_t ROWS [34] = '{
      '{1'h1, 16'h4E6B, 16'h0000, 32'h0, 2'h0, 5'h10, 32'h00005FF0},
      '{1'h1, 16'h4E65, 16'h0000, 32'h0, 2'h0, 5'h08, 32'hA0000005},
      '{1'h0, 16'h4E6B, 16'h0000, 32'h0, 2'h1, 5'h00, 32'h0},
      '{1'h1, 16'h4E7A, 16'h9801, 32'h0, 2'h0, 5'h10, 32'hC0000801},
      '{1'h1, 16'h4E7A, 16'h2000, 32'h0, 2'h0, 5'h10, 32'hC0000000},
      '{1'h1, 16'h4E7A, 16'h0001, 32'h0, 2'h0, 5'h10, 32'hC0000001},
      '{1'h1, 16'h4E7A, 16'h0800, 32'h0, 2'h0, 5'h10, 32'hC0000800},
      '{1'h1, 16'h4E7B, 16'hB803, 32'h0, 2'h0, 5'h08, 32'hD00D000B},
      '{1'h1, 16'h4E7B, 16'h1002, 32'h0, 2'h0, 5'h08, 32'hD00D0001},
      '{1'h1, 16'h4E7B, 16'h4804, 32'h0, 2'h0, 5'h08, 32'hD00D0004},
      '{1'h1, 16'h4E7A, 16'h0003, 32'h0, 2'h0, 5'h10, 32'hC0000003},
      '{1'h1, 16'h4E7A, 16'h0007, 32'h0, 2'h0, 5'h10, 32'hC0000007},
      '{1'h1, 16'h4E7A, 16'h0805, 32'h0, 2'h0, 5'h10, 32'hC0000805},
      '{1'h1, 16'h4E7A, 16'h0807, 32'h0, 2'h0, 5'h10, 32'hC0000807},
      '{1'h1, 16'h4E7A, 16'h0802, 32'h0, 2'h2, 5'h00, 32'h0},
      '{1'h1, 16'h4E7A, 16'h0808, 32'h0, 2'h2, 5'h00, 32'h0},
      '{1'h1, 16'h4E7A, 16'h0008, 32'h0, 2'h2, 5'h00, 32'h0},
      '{1'h0, 16'h4E7A, 16'h0801, 32'h0, 2'h1, 5'h00, 32'h0},
      '{1'h1, 16'h0E90, 16'h1800, 32'h0, 2'h0, 5'h04, 32'hD00D0001},
      '{1'h1, 16'h0E59, 16'hA000, 32'h0, 2'h0, 5'h14, 32'hFFFF8081},
      '{1'h1, 16'h0E39, 16'h8000, 32'h0, 2'h0, 5'h14, 32'hFFFFFF81},
      '{1'h1, 16'h0E80, 16'h1800, 32'h0, 2'h2, 5'h00, 32'h0},
      '{1'h1, 16'h0E88, 16'h1800, 32'h0, 2'h2, 5'h00, 32'h0},
      '{1'h1, 16'h0EBC, 16'h1800, 32'h0, 2'h2, 5'h00, 32'h0},
      '{1'h1, 16'h0EBA, 16'h0000, 32'h0, 2'h2, 5'h00, 32'h0},
      '{1'h1, 16'h0ED0, 16'h0000, 32'h0, 2'h0, 5'h00, 32'h0},
      '{1'h1, 16'h007C, 16'h0015, 32'h0, 2'h0, 5'h02, 32'h0000271D},
      '{1'h0, 16'h007C, 16'h0015, 32'h0, 2'h1, 5'h00, 32'h0},
      '{1'h1, 16'hF080, 16'h0000, 32'h0000FFF0, 2'h0, 5'h01, 32'h00000FF2},
      '{1'h1, 16'hF081, 16'h0000, 32'h0000FFF0, 2'h0, 5'h00, 32'h0},
      '{1'h1, 16'hF0C3, 16'h0000, 32'h00012340, 2'h0, 5'h01, 32'h00013342},
      '{1'h1, 16'hF08E, 16'h0000, 32'h00007FFE, 2'h0, 5'h01, 32'h00009000},
      '{1'h1, 16'h4E71, 16'h0000, 32'h0, 2'h0, 5'h00, 32'h0},
      '{1'h0, 16'hF080, 16'h0000, 32'h0000FFF0, 2'h1, 5'h00, 32'h0}};
   // Control value, expected space of a store
   localparam logic [7:0] SP_CTRL [4] = '{8'hC2, 8'h42, 8'hC6, 8'h46};
   localparam logic [2:0] SP_EXP [4] = '{3'h6, 3'h2, 3'h5, 3'h1};
   // Variant, expected exception, control code
   localparam logic [15:0] VR [7] = '{16'h2002, 16'h0801, 16'h2803, 16'h4802, 16'h6003, 16'hC004, 16'hE805};
   logic mclk = 1'h0;
   logic rst = 1'h1;
   instr_t instr = '0;
   logic supervisor = 1'h0;
   logic [31:0] an_val, rn_val, cr_val, mem_rdata, user_sp_val, pwdata, prdata, rd;
   logic [15:0] sr_val;
   logic [11:0] paddr;
   logic [5:0] cc_query;
   logic cc_true, psel, penable, pwrite, pready, pslverr, err;
   result_t result;
   int n_fail = 0;
   int total_checks = 0;

   always #20 mclk = ~mclk;

   privileged_instr_decoder dut (.mclk(mclk), .rst(rst), .instr(instr), .supervisor(supervisor),
      .an_val(an_val), .rn_val(rn_val), .cr_val(cr_val), .mem_rdata(mem_rdata), .sr_val(sr_val),
      .user_sp_val(user_sp_val), .cc_true(cc_true), .cc_query(cc_query), .result(result), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   core_side_model core (.instr(instr), .an_val(an_val), .rn_val(rn_val), .cr_val(cr_val),
      .mem_rdata(mem_rdata), .sr_val(sr_val), .user_sp_val(user_sp_val), .cc_true(cc_true));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One instruction; result is looked at once the taking edge has landed
   task automatic exec(input logic sup, input logic [15:0] op, input logic [15:0] ext, input logic [31:0] disp);
      @(posedge mclk);
      supervisor <= sup;
      instr <= '{1'h1, op, ext, disp, 32'h00001000};
      @(posedge mclk);
      instr.valid <= 1'h0;
      #1;
   endtask

   // Read data and pslverr are the values sampled at the completing edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int n = 0;
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'h1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   function automatic logic [38:0] pick(input result_t r);
      logic [31:0] v;
      v = r.pc_we ? r.pc_data : r.sr_we ? {16'h0, r.sr_data} :
         (r.cr_we | (r.mem_req & r.mem_write)) ? r.cr_data : r.gr_we ? r.gr_data : 32'h0;
      return {r.exc, r.gr_we, r.cr_we, r.mem_req, r.sr_we, r.pc_we, v};
   endfunction

   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (3) @(posedge mclk);
      rst <= 1'h0;
      apb(1'h0, ADDR_CTRL, 32'h0);
      check(rd, 32'h2);
      apb(1'h0, 12'h00C, 32'h0);
      check(err, 1'h1);
      $display("apb test done");
      foreach (ROWS[i]) begin
         exec(ROWS[i].sup, ROWS[i].op, ROWS[i].ext, ROWS[i].disp);
         check(pick(result), {ROWS[i].exc, ROWS[i].we, ROWS[i].v});
      end
      check({cc_query, result.cc_code}, {6'h0, 6'h0});
      $display("table test done");
      exec(1'h1, 16'h0E10, 16'h3000, 32'h0);
      check({result.gr_bmask, result.gr_data[7:0], result.mem_size}, {4'h1, 8'h81, SZ_BYTE});
      exec(1'h1, 16'h0E50, 16'h3000, 32'h0);
      check({result.gr_bmask, result.gr_data[15:0], result.mem_size}, {4'h3, 16'h8081, SZ_WORD});
      exec(1'h1, 16'h0E90, 16'h3000, 32'h0);
      check({result.gr_bmask, result.gr_data, result.mem_size}, {4'hF, 32'h12348081, SZ_LONG});
      exec(1'h1, 16'hF0C3, 16'h0000, 32'h00012340);
      check({cc_query, result.cc_code}, {6'h03, 6'h03});
      $display("size test done");
      apb(1'h1, ADDR_CTRL, 32'h0000000A);
      exec(1'h1, 16'h0E90, 16'h1000, 32'h0);
      check({result.mem_write, result.mem_space}, {1'h0, 3'h1});
      // Program-space stores reach memory as data-space ones when merged
      // Software is taken to have invalidated the instruction cache line before these stores
      foreach (SP_CTRL[i]) begin
         apb(1'h1, ADDR_CTRL, {24'h0, SP_CTRL[i]});
         exec(1'h1, 16'h0E90, 16'h1800, 32'h0);
         check({result.mem_write, result.mem_space}, {1'h1, SP_EXP[i]});
      end
      $display("space test done");
      foreach (VR[i]) begin
         apb(1'h1, ADDR_CTRL, {30'h0, VR[i][15:14]});
         exec(1'h1, 16'h4E7A, {4'h0, VR[i][11:0]}, 32'h0);
         check(result.exc, VR[i][13:12]);
      end
      exec(1'h0, 16'h007C, 16'h0015, 32'h0);
      check({result.sr_we, result.exc}, {1'h0, EXC_PRIV});
      apb(1'h0, ADDR_STATUS, 32'h0);
      check(rd, 32'h1);
      $display("variant test done");
      test_done();
   end

   initial begin
      repeat (4000) @(posedge mclk);
      n_fail++;
      test_done();
   end
endmodule
